// [hw/jtb_map.vh]
/*
 Constants for the test access port block: state codes, instruction codes,
 identification word layout and capture pattern.
 Assumes inclusion by bare name from the design files.
*/
`ifndef JTB_MAP_VH
`define JTB_MAP_VH

// Controller state codes, four bits each.
`define JTB_ST_RESET      4'h0
`define JTB_ST_IDLE       4'h1
`define JTB_ST_SEL_DR     4'h2
`define JTB_ST_CAP_DR     4'h3
`define JTB_ST_SH_DR      4'h4
`define JTB_ST_EX1_DR     4'h5
`define JTB_ST_PAU_DR     4'h6
`define JTB_ST_EX2_DR     4'h7
`define JTB_ST_UPD_DR     4'h8
`define JTB_ST_SEL_IR     4'h9
`define JTB_ST_CAP_IR     4'hA
`define JTB_ST_SH_IR      4'hB
`define JTB_ST_EX1_IR     4'hC
`define JTB_ST_PAU_IR     4'hD
`define JTB_ST_EX2_IR     4'hE
`define JTB_ST_UPD_IR     4'hF

// Instruction codes.
`define JTB_INS_EXTEST    4'h0
`define JTB_INS_SAMPLE    4'h1
`define JTB_INS_IDENT     4'h2
`define JTB_INS_HIGHZ     4'h3
`define JTB_INS_BYPASS    4'hF

// Instruction width and the value captured in Capture-IR.
`define JTB_IR_W          4
`define JTB_IR_CAPTURE    4'h1

// Identification word field positions.
`define JTB_ID_VER_HI     31
`define JTB_ID_VER_LO     28
`define JTB_ID_PART_HI    27
`define JTB_ID_PART_LO    12
`define JTB_ID_MAKER_HI   11
`define JTB_ID_MAKER_LO   1

`endif

// [hw/jtb_scan_chain.v]
/*
 Boundary scan chain: capture, shift and update stages for the port cells.
 Assumes the caller supplies one-cycle strobes on the system clock that stand
 for rising and falling test clock edges.
*/
`timescale 1ns/10ps
module jtb_scan_chain
#(
   parameter CELLS = 8
)
(
   // Clock and reset.
   input  wire             sys_clk,
   input  wire             resetn,
   // Control strobes.
   input  wire             capture,
   input  wire             shift,
   input  wire             update,
   input  wire             serial_in,
   // Parallel pin values and results.
   input  wire [CELLS-1:0] pin_value,
   output reg  [CELLS-1:0] shift_stage,
   output reg  [CELLS-1:0] update_stage
);

   // Shift stages load pin values or move one place toward the serial out.
   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_stage <= {CELLS{1'b0}};
      end
      else if (capture)
      begin
         shift_stage <= pin_value;
      end
      else if (shift)
      begin
         shift_stage <= {serial_in, shift_stage[CELLS-1:1]};
      end
   end

   // Update stages hold steady while shifting, so pins do not ripple.
   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         update_stage <= {CELLS{1'b0}};
      end
      else if (update)
      begin
         update_stage <= shift_stage;
      end
   end

endmodule // jtb_scan_chain

// [hw/jtb_tap.v]
/*
 Test access port: controller, instruction register, bypass, boundary scan
 and identification registers, serial output and pin override.
 Assumes tck, tms, tdi and trst_n arrive asynchronously from a tester and
 that the test clock is far slower than the system clock.
*/
`timescale 1ns/10ps
`include "jtb_map.vh"

// How it works
// - Five TMS-high test clocks reach reset.
// - Queue operation waits until controller reset.
// - States advance on rising test clock edge.
// - Reset state disables all test logic.
// - Idle state keeps test logic idle.
// - Select states branch data, instruction, reset.
// - Capture-IR loads pattern ending 01.
// - Shift-IR shifts instruction between TDI, TDO.
// - Exit-1 branches pause or update, Exit-2 shift or update.
// - Pause-IR holds shift contents.
// - Update-IR latches instruction on falling edge.
// - Capture-DR loads selected data register.
// - Data path mirrors instruction path.
// - Instruction is four bits, LSB nearest TDO.
// - Data registers parallel, instruction selects.
// - Bypass stage cleared in Capture-DR.
// - Bypass leaves function untouched.
// - Boundary register loads and reads pins.
// - Identification register is 32-bit read-only.
// - Word: version, part, maker, one.
// - Maker field is code without parity.
// - Instruction codes decode as listed.
// - High-impedance disables outputs, selects bypass.
module jtb_tap
#(
   parameter        CELLS      = 8,
   parameter [3:0]  VERSION    = 4'h1,    // Arbitrary value.
   parameter [15:0] PART_NUM   = 16'h1234, // Arbitrary value.
   parameter [10:0] MAKER_ID   = 11'h055   // Arbitrary value.
)
(
   // Clock and reset.
   input  wire             sys_clk,
   input  wire             resetn,
   // Test access port pins.
   input  wire             tck,
   input  wire             tms,
   input  wire             tdi,
   input  wire             trst_n,
   output reg              tdo_out,
   output reg              tdo_oe_n,
   // Core pins seen through the boundary cells.
   input  wire [CELLS-1:0] core_out,
   input  wire [CELLS-1:0] pin_in,
   output reg  [CELLS-1:0] pin_out,
   output reg              pin_oe_n,
   // Status toward the queue logic.
   output reg              queue_enable,
   output reg  [3:0]       tap_state
);

   // Synchronisers: the first stage feeds only the second.
   // Reset levels match the idle pins, so no false test clock edge and
   // no false test reset follows the release of resetn.
   reg [1:0] tck_sy;
   reg [1:0] tms_sy;
   reg [1:0] tdi_sy;
   reg [1:0] trst_sy;
   reg       tck_prev;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tck_sy   <= 2'h0;
         tms_sy   <= 2'h3;
         tdi_sy   <= 2'h3;
         trst_sy  <= 2'h3;
         tck_prev <= 1'b0;
      end
      else
      begin
         tck_sy   <= {tck_sy[0], tck};
         tms_sy   <= {tms_sy[0], tms};
         tdi_sy   <= {tdi_sy[0], tdi};
         trst_sy  <= {trst_sy[0], trst_n};
         tck_prev <= tck_sy[1];
      end
   end

   wire tck_rise = tck_sy[1] & ~tck_prev;
   wire tck_fall = ~tck_sy[1] & tck_prev;
   wire tms_s    = tms_sy[1];
   wire tdi_s    = tdi_sy[1];
   wire trst_act = ~trst_sy[1];

   // Controller state and next-state logic.
   reg  [3:0] state;
   reg  [3:0] next_state;

   // Next state from the synchronised mode level; it is used only on rises.
   always @*
   begin
      next_state = state;
      case (state)
         `JTB_ST_RESET:  next_state = tms_s ? `JTB_ST_RESET : `JTB_ST_IDLE;
         `JTB_ST_IDLE:   next_state = tms_s ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
         `JTB_ST_SEL_DR: next_state = tms_s ? `JTB_ST_SEL_IR
                                            : `JTB_ST_CAP_DR;
         `JTB_ST_CAP_DR: next_state = tms_s ? `JTB_ST_EX1_DR : `JTB_ST_SH_DR;
         `JTB_ST_SH_DR:  next_state = tms_s ? `JTB_ST_EX1_DR : `JTB_ST_SH_DR;
         `JTB_ST_EX1_DR: next_state = tms_s ? `JTB_ST_UPD_DR
                                            : `JTB_ST_PAU_DR;
         `JTB_ST_PAU_DR: next_state = tms_s ? `JTB_ST_EX2_DR : `JTB_ST_PAU_DR;
         `JTB_ST_EX2_DR: next_state = tms_s ? `JTB_ST_UPD_DR
                                            : `JTB_ST_SH_DR;
         `JTB_ST_UPD_DR: next_state = tms_s ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
         `JTB_ST_SEL_IR: next_state = tms_s ? `JTB_ST_RESET
                                            : `JTB_ST_CAP_IR;
         `JTB_ST_CAP_IR: next_state = tms_s ? `JTB_ST_EX1_IR : `JTB_ST_SH_IR;
         `JTB_ST_SH_IR:  next_state = tms_s ? `JTB_ST_EX1_IR : `JTB_ST_SH_IR;
         `JTB_ST_EX1_IR: next_state = tms_s ? `JTB_ST_UPD_IR
                                            : `JTB_ST_PAU_IR;
         `JTB_ST_PAU_IR: next_state = tms_s ? `JTB_ST_EX2_IR : `JTB_ST_PAU_IR;
         `JTB_ST_EX2_IR: next_state = tms_s ? `JTB_ST_UPD_IR
                                            : `JTB_ST_SH_IR;
         `JTB_ST_UPD_IR: next_state = tms_s ? `JTB_ST_SEL_DR : `JTB_ST_IDLE;
         default:        next_state = `JTB_ST_RESET;
      endcase
   end

   // The controller has no power-up reset of its own by design; the system
   // reset only gives simulation a known start, and the tester must still
   // reset it before queue traffic is allowed.
   reg        was_reset;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state     <= `JTB_ST_IDLE;
         was_reset <= 1'b0;
      end
      else if (trst_act)
      begin
         state     <= `JTB_ST_RESET;
         was_reset <= 1'b1;
      end
      else if (tck_rise)
      begin
         state     <= next_state;
         if (next_state == `JTB_ST_RESET)
         begin
            was_reset <= 1'b1;
         end
      end
   end

   // Instruction shift stages and the current instruction.
   reg [`JTB_IR_W-1:0] ir_shift;
   reg [`JTB_IR_W-1:0] ir_hold;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ir_shift <= `JTB_IR_CAPTURE;
      end
      else if (tck_rise && state == `JTB_ST_CAP_IR)
      begin
         ir_shift <= `JTB_IR_CAPTURE;
      end
      else if (tck_rise && state == `JTB_ST_SH_IR)
      begin
         ir_shift <= {tdi_s, ir_shift[`JTB_IR_W-1:1]};
      end
      // Pause-IR and the exits leave the stages untouched.
   end

   // Reset chooses identification, so it can be read straight away.
   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ir_hold <= `JTB_INS_IDENT;
      end
      else if (state == `JTB_ST_RESET)
      begin
         ir_hold <= `JTB_INS_IDENT;
      end
      else if (tck_fall && state == `JTB_ST_UPD_IR)
      begin
         ir_hold <= ir_shift;
      end
   end

   // Instruction decode; any other code falls back to bypass.
   wire sel_bsr = (ir_hold == `JTB_INS_EXTEST) ||
                  (ir_hold == `JTB_INS_SAMPLE);
   wire sel_id  = (ir_hold == `JTB_INS_IDENT);
   wire sel_byp = ~sel_bsr & ~sel_id;
   wire extest  = (ir_hold == `JTB_INS_EXTEST);
   wire highz   = (ir_hold == `JTB_INS_HIGHZ);

   wire cap_dr = tck_rise && state == `JTB_ST_CAP_DR;
   wire sh_dr  = tck_rise && state == `JTB_ST_SH_DR;
   wire upd_dr = tck_fall && state == `JTB_ST_UPD_DR;

   // Bypass stage and identification shifter.
   reg        byp_stage;
   reg [31:0] id_shift;
   wire [31:0] id_word;

   // Fields go to their declared positions; bit 0 is always one.
   assign id_word[`JTB_ID_VER_HI:`JTB_ID_VER_LO]     = VERSION;
   assign id_word[`JTB_ID_PART_HI:`JTB_ID_PART_LO]   = PART_NUM;
   assign id_word[`JTB_ID_MAKER_HI:`JTB_ID_MAKER_LO] = MAKER_ID;
   assign id_word[0]                                 = 1'b1;

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         byp_stage <= 1'b0;
         id_shift  <= 32'h0000_0000;
      end
      else
      begin
         if (sel_byp && cap_dr)
         begin
            byp_stage <= 1'b0;
         end
         else if (sel_byp && sh_dr)
         begin
            byp_stage <= tdi_s;
         end
         if (sel_id && cap_dr)
         begin
            id_shift <= id_word;
         end
         else if (sel_id && sh_dr)
         begin
            id_shift <= {tdi_s, id_shift[31:1]};
         end
      end
   end

   // Boundary cells: pin inputs then core outputs form the capture word.
   wire [2*CELLS-1:0] bsr_shift;
   wire [2*CELLS-1:0] bsr_update;

   jtb_scan_chain #(
      .CELLS        (2*CELLS)
   ) jtb_scan_chain_inst (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .capture      (sel_bsr & cap_dr),
      .shift        (sel_bsr & sh_dr),
      .update       (sel_bsr & upd_dr),
      .serial_in    (tdi_s),
      .pin_value    ({core_out, pin_in}),
      .shift_stage  (bsr_shift),
      .update_stage (bsr_update)
   );

   // Serial output and pin drive, all from flip-flops.
   wire shifting = (state == `JTB_ST_SH_DR) || (state == `JTB_ST_SH_IR);
   wire dr_bit   = sel_id  ? id_shift[0] :
                   sel_bsr ? bsr_shift[0] : byp_stage;
   wire ser_bit  = (state == `JTB_ST_SH_IR) ? ir_shift[0] : dr_bit;

   // The serial output moves about three system clocks after the pin falls,
   // so the test clock must stay well below the system clock rate.

   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tdo_out      <= 1'b0;
         tdo_oe_n     <= 1'b1;
         pin_out      <= {CELLS{1'b0}};
         pin_oe_n     <= 1'b1;
         queue_enable <= 1'b0;
         tap_state    <= `JTB_ST_IDLE;
      end
      else
      begin
         if (tck_fall)
         begin
            tdo_out  <= ser_bit;
            tdo_oe_n <= ~shifting;
         end
         // Only EXTEST steers pin values; HIGHZ turns the pins off; other codes pass the core through.
         pin_out      <= extest ? bsr_update[2*CELLS-1:CELLS]
                                : core_out;
         pin_oe_n     <= highz;
         queue_enable <= was_reset & ~extest & ~highz;
         tap_state    <= state;
      end
   end

endmodule // jtb_tap

// [verif/jtb_tap_properties.sv]
/*
 Checker for the test access port: properties on pins and status ports.
 Assumes a test clock several system clocks long and the bind below.
*/
`timescale 1ns/10ps
`include "jtb_map.vh"
module jtb_tap_properties
(
   // Clock and reset.
   input wire       sys_clk,
   input wire       resetn,
   // Watched ports.
   input wire       tck,
   input wire       tms,
   input wire       trst_n,
   input wire       tdo_out,
   input wire       tdo_oe_n,
   input wire       pin_oe_n,
   input wire       queue_enable,
   input wire [3:0] tap_state
);
   reg       tck_q;
   reg [2:0] ones;
   // Counts test clock rises with tms high; a low tms restarts it.
   always @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tck_q <= 1'b0;
         ones  <= 3'h0;
      end
      else
      begin
         tck_q <= tck;
         if (tck && !tck_q)
            ones <= !tms ? 3'h0 : (ones == 3'h7) ? ones : ones + 3'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   tms_five_a: assert property ($rose(ones == 3'h5) |->
      ##[1:6] tap_state == `JTB_ST_RESET) else $error("no reset by tms");
   trst_hold_a: assert property (!trst_n [*6] |->
      tap_state == `JTB_ST_RESET) else $error("no reset by trst");
   oe_shift_a: assert property (!tdo_oe_n |-> tap_state inside
      {`JTB_ST_SH_DR, `JTB_ST_EX1_DR, `JTB_ST_SH_IR, `JTB_ST_EX1_IR})
      else $error("tdo driven outside shift");
   tdo_fall_a: assert property ($changed(tdo_out) |->
      !$past(tck, 2)) else $error("tdo moved off falling edge");
   oe_fall_a: assert property ($changed(tdo_oe_n) |->
      !$past(tck, 2)) else $error("tdo enable moved off falling edge");
   state_rise_a: assert property ($changed(tap_state) && trst_n |->
      $past(tck, 2)) else $error("state moved off rising edge");
   highz_queue_a: assert property (pin_oe_n [*3] |->
      !queue_enable) else $error("queue on with pins off");
   queue_rise_a: assert property ($rose(queue_enable) |->
      tap_state inside {`JTB_ST_RESET, `JTB_ST_UPD_IR})
      else $error("queue enabled out of place");
endmodule // jtb_tap_properties

bind jtb_tap jtb_tap_properties jtb_tap_properties_inst (
   .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms),
   .trst_n(trst_n), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
   .pin_oe_n(pin_oe_n), .queue_enable(queue_enable),
   .tap_state(tap_state));

// [verif/jtb_tester.sv]
/*
 Tester model: drives the test clock, mode, data and reset pins.
 Assumes its tasks are entered at a falling system clock edge.
*/
`timescale 1ns/10ps
module jtb_tester
(
   // Pacing clock.
   input  wire sys_clk,
   // Test access port wires.
   output reg  tck,
   output reg  tms,
   output reg  tdi,
   output reg  trst_n,
   input  wire tdo_out,
   input  wire tdo_oe_n
);
   reg  last;
   // A released serial line shows the inverse of its last level.
   wire tdo_line = tdo_oe_n ? ~last : tdo_out;
   // The test clock stands high between frames.
   initial
   begin
      tck    = 1'b0;
      tms    = 1'b1;
      tdi    = 1'b0;
      trst_n = 1'b1;
      last   = 1'b0;
   end
   // One 160 ns test clock: sample at the rise, as a tester does.
   task step(input m, input d, output o);
   begin
      tms = m;
      tdi = d;
      tck = 1'b0;
      repeat (4) @(negedge sys_clk);
      o = tdo_line;
      last = o;
      tck = 1'b1;
      repeat (4) @(negedge sys_clk);
   end
   endtask
   // Test reset held long enough for the synchroniser.
   task hard_reset;
   begin
      trst_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      trst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
   end
   endtask
   // From reset or idle to a shift state of either path.
   task to_shift(input ir);
   reg o;
   begin
      step(1'b0, 1'b0, o);
      step(1'b1, 1'b0, o);
      if (ir)
         step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
   end
   endtask
   // Shifts n bits LSB first, leaves on the last, updates, idles.
   task scan(input ir, input [31:0] din, input integer n,
             output [31:0] dout);
   integer i;
   reg     o;
   begin
      dout = 32'h0;
      to_shift(ir);
      for (i = 0; i < n; i = i + 1)
      begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   end
   endtask
endmodule // jtb_tester

// [verif/jtb_tap_tb.sv]
/*
 Testbench for the test access port with a tester model on its pins.
 Assumes the design, header and checker are compiled beforehand.
*/
`timescale 1ns/10ps
`include "jtb_map.vh"
module jtb_tap_tb;
   localparam [3:0]  VER  = 4'hA;     // Arbitrary value.
   localparam [15:0] PART = 16'h5A5A; // Arbitrary value.
   localparam [10:0] MAKR = 11'h2C3;  // Arbitrary value.
   reg         sys_clk;
   reg         resetn;
   reg  [7:0]  core_out;
   reg  [7:0]  pin_in;
   wire        tck, tms, tdi, trst_n, tdo_out, tdo_oe_n;
   wire [7:0]  pin_out;
   wire        pin_oe_n, queue_enable;
   wire [3:0]  tap_state;
   integer     error_cnt, compares, cyc;
   reg  [31:0] got;
   reg         b;
   jtb_tap #(.CELLS(8), .VERSION(VER), .PART_NUM(PART), .MAKER_ID(MAKR))
   jtb_tap_inst (.sys_clk(sys_clk), .resetn(resetn), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_out(tdo_out),
      .tdo_oe_n(tdo_oe_n), .core_out(core_out), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .queue_enable(queue_enable), .tap_state(tap_state));
   jtb_tester jtb_tester_inst (.sys_clk(sys_clk), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n), .tdo_out(tdo_out),
      .tdo_oe_n(tdo_oe_n));
   // The only compare; case inequality keeps unknowns failing.
   task chk(input [31:0] g, input [31:0] e, input string what);
   begin
      compares = compares + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t %0s got %h want %h", $time, what, g, e);
      end
   end
   endtask
   // Prints the counts and the verdict, then stops.
   task end_sim;
   begin
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   // Queue held off until the port is reset; the word reads at once.
   task t_power_up;
   begin
      chk({31'h0, queue_enable}, 32'h0, "queue early");
      jtb_tester_inst.hard_reset;
      chk({28'h0, tap_state}, `JTB_ST_RESET, "trst");
      chk({31'h0, queue_enable}, 32'h1, "queue on");
      jtb_tester_inst.scan(1'b0, 32'h0, 32, got);
      chk(got, {VER, PART, MAKR, 1'b1}, "ident");
      chk({28'h0, tap_state}, `JTB_ST_IDLE, "idle");
   end
   endtask
   // Four high tms steps from Shift-DR stop one short of reset.
   task t_tms_reset;
   begin
      jtb_tester_inst.to_shift(1'b0);
      repeat (4) jtb_tester_inst.step(1'b1, 1'b0, b);
      chk({28'h0, tap_state}, `JTB_ST_SEL_IR, "sel ir");
      jtb_tester_inst.step(1'b1, 1'b0, b);
      chk({28'h0, tap_state}, `JTB_ST_RESET, "tms five");
   end
   endtask
   // Loads a code that must select the one-stage pass-through.
   task t_bypass(input [3:0] code);
   begin
      jtb_tester_inst.scan(1'b1, {28'h0, code}, 4, got);
      chk(got, {28'h0, `JTB_IR_CAPTURE}, "ir cap");
      jtb_tester_inst.scan(1'b0, 32'hB5, 8, got);
      chk(got, 32'h6A, "bypass");
      chk({31'h0, queue_enable}, 32'h1, "queue bypass");
   end
   endtask
   // High impedance turns the pins off and still passes through.
   task t_highz;
   begin
      jtb_tester_inst.scan(1'b1, `JTB_INS_HIGHZ, 4, got);
      chk({31'h0, pin_oe_n}, 32'h1, "pins off");
      chk({31'h0, queue_enable}, 32'h0, "queue off");
      jtb_tester_inst.scan(1'b0, 32'hC3, 8, got);
      chk(got, 32'h86, "highz path");
   end
   endtask
   // Sample then preload, then external test drives the cells out.
   task t_boundary;
   begin
      jtb_tester_inst.scan(1'b1, `JTB_INS_SAMPLE, 4, got);
      chk({24'h0, pin_out}, {24'h0, core_out}, "sample pins");
      chk({31'h0, pin_oe_n}, 32'h0, "pins on");
      jtb_tester_inst.scan(1'b0, 32'hE71B, 16, got);
      chk(got, {16'h0, core_out, pin_in}, "capture");
      jtb_tester_inst.scan(1'b1, `JTB_INS_EXTEST, 4, got);
      chk({24'h0, pin_out}, 32'hE7, "extest out");
      chk({31'h0, queue_enable}, 32'h0, "queue test");
   end
   endtask
   // A paused instruction scan keeps its bits and resumes where it stopped.
   task t_pause;
   reg [3:0] o;
   begin
      jtb_tester_inst.to_shift(1'b1);
      jtb_tester_inst.step(1'b0, 1'b1, o[0]);
      jtb_tester_inst.step(1'b1, 1'b1, o[1]);
      jtb_tester_inst.step(1'b0, 1'b1, b);
      jtb_tester_inst.step(1'b0, 1'b1, b);
      chk({28'h0, tap_state}, `JTB_ST_PAU_IR, "pause ir");
      chk({31'h0, tdo_oe_n}, 32'h1, "oe paused");
      jtb_tester_inst.step(1'b1, 1'b1, b);
      jtb_tester_inst.step(1'b0, 1'b1, b);
      jtb_tester_inst.step(1'b0, 1'b0, o[2]);
      jtb_tester_inst.step(1'b1, 1'b0, o[3]);
      jtb_tester_inst.step(1'b1, 1'b0, b);
      jtb_tester_inst.step(1'b0, 1'b0, b);
      chk({28'h0, o}, {28'h0, `JTB_IR_CAPTURE}, "paused ir");
      chk({31'h0, pin_oe_n}, 32'h1, "paused load");
   end
   endtask
   // Free-running system clock.
   always #10 sys_clk = ~sys_clk;
   // Cuts a hang short; the run needs about 1,500 cycles.
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         end_sim;
      end
   end
   // Drives every input from time zero and runs the scenarios.
   initial
   begin
      sys_clk   = 1'b0;
      resetn    = 1'b0;
      core_out  = 8'h3C;
      pin_in    = 8'h81;
      error_cnt = 0;
      compares  = 0;
      cyc       = 0;
      repeat (8) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_power_up;
      t_tms_reset;
      t_bypass(`JTB_INS_BYPASS);
      t_bypass(4'h5);
      t_highz;
      t_boundary;
      t_pause;
      end_sim;
   end
endmodule // jtb_tap_tb
